// file: rxtc_regs.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Operation
// [R1] serial bytes 15..8 up to 31..24 readable
// [R2] serial byte 7..0 readable below
// [R3] radio path disable bit switches path off
// [R4] four-bit if attenuation, sixteen steps
// [R5] twenty-bit divider split over three registers
// [R6] output period is twice divider clocks
// [R7] divider zero means two to twentieth
// [R8] divider low resets 07, others zero
// [R9] injection side bit; other bits written zero
// [R10] five-bit slope trim, reset 0C
// [R11] two-bit rssi pin signal select
// [R12] bit four switches rssi pin buffer
// [R13] four-bit offset trim, register reset 15
// [R14] on-time periods: value, zero means 16384
// [R15] two on-time low bytes, reset 01
// [R16] on-time bits 13..8 separate per configuration
// [R17] upper six bits in following register
// [R18] serial writes ignored, reads harmless
// [R19] multi-byte values used only when complete
// ============================================================
module rxtc_regs
  import rxtc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,                        // low freezes all state
  input wire logic [31:0] factory_serial,     // fused serial number
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // block outputs
  output rxtc_trim_type trim,                 // analogue trim settings
  output logic [DIV_W-1:0] clock_divider,     // committed divider value
  output logic clock_out,                     // divided clock
  output rxtc_on_time_type on_time_a,         // configuration a on-time
  output rxtc_on_time_type on_time_b          // configuration b on-time
);

  // ==========================================================
  // write channel holding
  // ==========================================================
  logic aw_full;                  // address taken, waiting for data
  logic w_full;                   // data taken, waiting for address
  logic [ADDR_W-1:0] aw_addr_q;   // held write address
  logic [7:0] w_byte_q;           // held write byte, lane 0
  logic w_lane_q;                 // lane 0 strobe was set
  logic do_write;                 // both halves present, response free
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic next_aw_full;
  logic next_w_full;
  logic next_bvalid;
  logic next_rvalid;
  rxtc_reg_type wr_reg;           // decoded write target
  rxtc_reg_type rd_reg;           // decoded read target

  // staged lower bytes, used only once the top byte lands
  logic [7:0] div_low;
  logic [7:0] div_mid;
  logic [7:0] ona_low;
  logic [7:0] onb_low;
  logic div_pending;              // lower divider bytes written, not committed
  logic ona_pending;
  logic onb_pending;

  // divider counter
  logic [DIV_W-1:0] div_count;
  logic [DIV_W-1:0] div_limit;

  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  // response channel must be free, so one write at a time
  assign do_write = aw_full & w_full & ~bvalid;
  assign next_aw_full = (aw_full | aw_take) & ~do_write;
  assign next_w_full = (w_full | w_take) & ~do_write;
  assign next_bvalid = do_write | (bvalid & ~bready);
  assign next_rvalid = ar_take | (rvalid & ~rready);
  assign wr_reg = rxtc_decode(aw_addr_q[IDX_LSB +: 7]);
  assign rd_reg = rxtc_decode(araddr[IDX_LSB +: 7]);

  // periods for an on-time set value: zero stands for 16384
  function automatic logic [ON_W:0] on_periods(input logic [ON_W-1:0] v);
    on_periods = (v == '0) ? {1'b1, {ON_W{1'b0}}} : {1'b0, v};   // [R14]
  endfunction : on_periods

  // ==========================================================
  // write address and data capture
  // ==========================================================
  // each half is taken on its own; order between them is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (ce) begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= ~next_aw_full;
      wready <= ~next_w_full;
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
    end
  end

  // ==========================================================
  // write response
  // ==========================================================
  // unmapped index answers slverr; read-only targets answer okay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      bvalid <= next_bvalid;
      if (do_write) begin
        bresp <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ==========================================================
  // trim registers
  // ==========================================================
  // a write without lane 0 strobe changes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim.radio_path_disable <= RST_RADIO[RADIO_OFF_BIT];
      trim.if_attenuation <= RST_RADIO[3:0];
      trim.injection_side_select <= RST_OSC[INJ_SIDE_BIT];
      trim.rssi_slope_trim <= RST_GAIN[4:0];                       // [R10]
      trim.rssi_pin_signal_select <= RST_OFFSET[SIG_SEL_LSB +: 2];
      trim.rssi_pin_buffer_enable <= RST_OFFSET[BUF_EN_BIT];
      trim.rssi_offset_trim <= RST_OFFSET[3:0];                    // [R13]
    end else if (ce && do_write && w_lane_q) begin
      case (wr_reg)
        REG_RADIO: begin
          trim.radio_path_disable <= w_byte_q[RADIO_OFF_BIT];      // [R3]
          trim.if_attenuation <= w_byte_q[3:0];                    // [R4]
        end
        REG_OSC: begin
          // other bits must be written zero and are not stored
          trim.injection_side_select <= w_byte_q[INJ_SIDE_BIT];    // [R9]
        end
        REG_GAIN: begin
          trim.rssi_slope_trim <= w_byte_q[4:0];                   // [R10]
        end
        REG_OFFSET: begin
          trim.rssi_pin_signal_select <= w_byte_q[SIG_SEL_LSB +: 2]; // [R11]
          trim.rssi_pin_buffer_enable <= w_byte_q[BUF_EN_BIT];     // [R12]
          trim.rssi_offset_trim <= w_byte_q[3:0];                  // [R13]
        end
        default: begin
          // serial bytes and others: nothing stored here [R18]
        end
      endcase
    end
  end

  // ==========================================================
  // clock divider staging and commit
  // ==========================================================
  // the counter only sees a full value, never a half-written one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_low <= RST_DIV_LOW;                                      // [R8]
      div_mid <= RST_DIV_MID;
      div_pending <= 1'b0;
      clock_divider <= {RST_DIV_HIGH[3:0], RST_DIV_MID, RST_DIV_LOW}; // [R8]
    end else if (ce && do_write && w_lane_q) begin
      case (wr_reg)
        REG_DIV_LOW: begin
          div_low <= w_byte_q;                                     // [R5]
          div_pending <= 1'b1;
        end
        REG_DIV_MID: begin
          div_mid <= w_byte_q;                                     // [R5]
          div_pending <= 1'b1;
        end
        REG_DIV_HIGH: begin
          clock_divider <= {w_byte_q[3:0], div_mid, div_low};      // [R5] [R19]
          div_pending <= 1'b0;
        end
        default: begin
          // not a divider register
        end
      endcase
    end
  end

  // ==========================================================
  // clock output generation
  // ==========================================================
  // toggles every divider cycles, so period is twice the value;
  // minus one wraps zero to all ones, which is 2^20 cycles
  assign div_limit = clock_divider - {{(DIV_W-1){1'b0}}, 1'b1};    // [R7]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= '0;
      clock_out <= 1'b0;
    end else if (ce) begin
      if (do_write && w_lane_q && wr_reg == REG_DIV_HIGH) begin
        // restart so the new ratio begins cleanly
        div_count <= '0;
      end else if (div_count >= div_limit) begin
        div_count <= '0;
        clock_out <= ~clock_out;                                   // [R6]
      end else begin
        div_count <= div_count + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // polling on-time, configurations a and b
  // ==========================================================
  // low byte staged, whole value committed by the upper register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ona_low <= RST_ON_LOW;                                       // [R15]
      onb_low <= RST_ON_LOW;                                       // [R15]
      ona_pending <= 1'b0;
      onb_pending <= 1'b0;
      on_time_a.set_value <= {RST_ON_HIGH[ON_HIGH_W-1:0], RST_ON_LOW};
      on_time_a.periods <= on_periods({RST_ON_HIGH[ON_HIGH_W-1:0], RST_ON_LOW});
      on_time_b.set_value <= {RST_ON_HIGH[ON_HIGH_W-1:0], RST_ON_LOW};
      on_time_b.periods <= on_periods({RST_ON_HIGH[ON_HIGH_W-1:0], RST_ON_LOW});
    end else if (ce && do_write && w_lane_q) begin
      case (wr_reg)
        REG_ONA_LOW: begin
          ona_low <= w_byte_q;                                     // [R15]
          ona_pending <= 1'b1;
        end
        REG_ONB_LOW: begin
          onb_low <= w_byte_q;                                     // [R15]
          onb_pending <= 1'b1;
        end
        REG_ONA_HIGH: begin
          on_time_a.set_value <= {w_byte_q[ON_HIGH_W-1:0], ona_low}; // [R16] [R17] [R19]
          on_time_a.periods <= on_periods({w_byte_q[ON_HIGH_W-1:0], ona_low}); // [R14]
          ona_pending <= 1'b0;
        end
        REG_ONB_HIGH: begin
          on_time_b.set_value <= {w_byte_q[ON_HIGH_W-1:0], onb_low}; // [R16] [R17] [R19]
          on_time_b.periods <= on_periods({w_byte_q[ON_HIGH_W-1:0], onb_low}); // [R14]
          onb_pending <= 1'b0;
        end
        default: begin
          // not an on-time register
        end
      endcase
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  // data is fixed at the take; write-only targets read zero and
  // are left untouched, since a read has no side effect here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rresp <= (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        case (rd_reg)
          REG_SERIAL0: rdata <= {24'h000000, factory_serial[7:0]};   // [R2]
          REG_SERIAL1: rdata <= {24'h000000, factory_serial[15:8]};  // [R1]
          REG_SERIAL2: rdata <= {24'h000000, factory_serial[23:16]}; // [R1]
          REG_SERIAL3: rdata <= {24'h000000, factory_serial[31:24]}; // [R1]
          REG_STATUS: rdata <= {28'h0000000, onb_pending, ona_pending,
                                div_pending, clock_out};
          default: rdata <= 32'h0000_0000;                         // [R18]
        endcase
      end
    end
  end

endmodule : rxtc_regs
`default_nettype wire

// file: rxtc_pkg.sv
// ============================================================
// shared constants and types for the receiver trim bank
// ============================================================
package rxtc_pkg;

  // ==========================================================
  // bus geometry
  // ==========================================================
  localparam int ADDR_W = 12;                 // byte address width
  localparam int IDX_LSB = 2;                 // index = byte address / 4
  localparam logic [1:0] RESP_OKAY = 2'h0;    // normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // unmapped index

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [6:0] IDX_SERIAL0 = 7'h0E;
  localparam logic [6:0] IDX_SERIAL1 = 7'h0F;
  localparam logic [6:0] IDX_SERIAL2 = 7'h10;
  localparam logic [6:0] IDX_SERIAL3 = 7'h11;
  localparam logic [6:0] IDX_RADIO = 7'h12;
  localparam logic [6:0] IDX_DIV_LOW = 7'h13;
  localparam logic [6:0] IDX_DIV_MID = 7'h14;
  localparam logic [6:0] IDX_DIV_HIGH = 7'h15;
  localparam logic [6:0] IDX_OSC = 7'h16;
  localparam logic [6:0] IDX_GAIN = 7'h1B;
  localparam logic [6:0] IDX_OFFSET = 7'h1C;
  localparam logic [6:0] IDX_ONA_LOW = 7'h1F;
  localparam logic [6:0] IDX_ONA_HIGH = 7'h20;
  localparam logic [6:0] IDX_ONB_LOW = 7'h40;
  localparam logic [6:0] IDX_ONB_HIGH = 7'h41;
  localparam logic [6:0] IDX_STATUS = 7'h50;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0] RST_RADIO = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h07;
  localparam logic [7:0] RST_DIV_MID = 8'h00;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_OSC = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h0C;
  localparam logic [7:0] RST_OFFSET = 8'h15;
  localparam logic [7:0] RST_ON_LOW = 8'h01;
  localparam logic [7:0] RST_ON_HIGH = 8'h00;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int RADIO_OFF_BIT = 4;   // radio path disable
  localparam int INJ_SIDE_BIT = 4;    // injection side select
  localparam int BUF_EN_BIT = 4;      // rssi pin buffer enable
  localparam int SIG_SEL_LSB = 5;     // rssi pin signal select, 2 bits
  localparam int DIV_W = 20;          // clock out divider width
  localparam int ON_W = 14;           // on-time set value width
  localparam int ON_HIGH_W = 6;       // on-time upper byte width

  // ==========================================================
  // decoded register identity
  // ==========================================================
  typedef enum logic [4:0] {
    REG_NONE, REG_SERIAL0, REG_SERIAL1, REG_SERIAL2, REG_SERIAL3,
    REG_RADIO, REG_DIV_LOW, REG_DIV_MID, REG_DIV_HIGH, REG_OSC,
    REG_GAIN, REG_OFFSET, REG_ONA_LOW, REG_ONA_HIGH, REG_ONB_LOW,
    REG_ONB_HIGH, REG_STATUS
  } rxtc_reg_type;

  // analogue trim settings, travelling together
  typedef struct packed {
    logic radio_path_disable;
    logic [3:0] if_attenuation;
    logic injection_side_select;
    logic [4:0] rssi_slope_trim;
    logic [1:0] rssi_pin_signal_select;
    logic rssi_pin_buffer_enable;
    logic [3:0] rssi_offset_trim;
  } rxtc_trim_type;

  // one polling configuration: raw set value and period count
  typedef struct packed {
    logic [ON_W-1:0] set_value;
    logic [ON_W:0] periods;
  } rxtc_on_time_type;

  // index to register identity, shared by read and write paths
  function automatic rxtc_reg_type rxtc_decode(input logic [6:0] idx);
    case (idx)
      IDX_SERIAL0: rxtc_decode = REG_SERIAL0;
      IDX_SERIAL1: rxtc_decode = REG_SERIAL1;
      IDX_SERIAL2: rxtc_decode = REG_SERIAL2;
      IDX_SERIAL3: rxtc_decode = REG_SERIAL3;
      IDX_RADIO: rxtc_decode = REG_RADIO;
      IDX_DIV_LOW: rxtc_decode = REG_DIV_LOW;
      IDX_DIV_MID: rxtc_decode = REG_DIV_MID;
      IDX_DIV_HIGH: rxtc_decode = REG_DIV_HIGH;
      IDX_OSC: rxtc_decode = REG_OSC;
      IDX_GAIN: rxtc_decode = REG_GAIN;
      IDX_OFFSET: rxtc_decode = REG_OFFSET;
      IDX_ONA_LOW: rxtc_decode = REG_ONA_LOW;
      IDX_ONA_HIGH: rxtc_decode = REG_ONA_HIGH;
      IDX_ONB_LOW: rxtc_decode = REG_ONB_LOW;
      IDX_ONB_HIGH: rxtc_decode = REG_ONB_HIGH;
      IDX_STATUS: rxtc_decode = REG_STATUS;
      default: rxtc_decode = REG_NONE;
    endcase
  endfunction : rxtc_decode

endpackage : rxtc_pkg

// file: rxtc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checker for the trim bank
// ============================================================
module rxtc_regs_asserts
  import rxtc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire rxtc_trim_type trim,
  input wire logic [DIV_W-1:0] clock_divider,
  input wire logic clock_out,
  input wire rxtc_on_time_type on_time_a,
  input wire rxtc_on_time_type on_time_b
);
  logic [21:0] gap;              // cycles since last output toggle
  logic prev_out;                // output level one cycle back
  logic [DIV_W-1:0] prev_div;    // divider one cycle back
  logic clean;                   // no divider change since last toggle
  // ============================================================
  // toggle spacing helper; a commit restarts it, so it is not judged
  // ============================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 22'h0;
      prev_out <= 1'b0;
      prev_div <= '0;
      clean <= 1'b0;
    end else if (ce) begin
      prev_out <= clock_out;
      prev_div <= clock_divider;
      gap <= (clock_out != prev_out) ? 22'h1 : gap + 22'h1;
      if (clock_out != prev_out) clean <= 1'b1;
      if (clock_divider != prev_div) clean <= 1'b0; // last write wins
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rlat; ce && arvalid && arready |=> rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhigh; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_rhigh: assert property (p_rhigh) else $error("upper read bits set");
  property p_err; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read carries data");
  property p_trim; !$stable(trim) |-> $rose(bvalid) || $past(!aresetn); endproperty
  a_trim: assert property (p_trim) else $error("trim moved without a write");
  property p_div; !$stable(clock_divider) |-> $rose(bvalid) || $past(!aresetn); endproperty
  a_div: assert property (p_div) else $error("divider moved without a write");
  property p_ona; !$stable(on_time_a) |-> $rose(bvalid) || $past(!aresetn); endproperty
  a_ona: assert property (p_ona) else $error("on-time moved without a write");
  property p_pera;
    on_time_a.periods == ((on_time_a.set_value == '0) ? 15'h4000 : {1'b0, on_time_a.set_value});
  endproperty
  a_pera: assert property (p_pera) else $error("period count a wrong");
  property p_perb;
    on_time_b.periods == ((on_time_b.set_value == '0) ? 15'h4000 : {1'b0, on_time_b.set_value});
  endproperty
  a_perb: assert property (p_perb) else $error("period count b wrong");
  property p_gap;
    ce && clean && clock_out != prev_out |->
      gap == ((clock_divider == '0) ? 22'h100000 : 22'(clock_divider));
  endproperty
  a_gap: assert property (p_gap) else $error("half period wrong");
  property p_rst;
    $rose(aresetn) |-> clock_divider == 20'h7 && trim.rssi_slope_trim == 5'h0C
      && {trim.rssi_pin_signal_select, trim.rssi_pin_buffer_enable} == 3'h1
      && trim.rssi_offset_trim == 4'h5 && on_time_b.set_value == 14'h1;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : rxtc_regs_asserts
`default_nettype wire

// file: tb_receiver_trim_and_clock_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench with a behavioural register model
// ============================================================
module tb_receiver_trim_and_clock_regs
  import rxtc_pkg::*;
;
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, factory_serial = 0;
  logic [3:0] wstrb = 0;
  logic [2:0] awprot = 0, arprot = 0;
  logic awready, wready, bvalid, arready, rvalid, clock_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic held;                  // divided clock level when frozen
  logic [13:0] on_vals [4];    // on-time set values, boundaries first
  logic [19:0] clock_divider;
  rxtc_trim_type trim;
  rxtc_on_time_type on_time_a, on_time_b;
  // model state, reset values included
  int m_radio = 0, m_osc = 0, m_gain = 'h0C, m_off = 'h15, m_div = 7;
  int st_lo = 7, st_mid = 0, ona = 1, onb = 1, sta = 1, stb = 1, i;
  int err_count = 0, total_checks = 0, cycles = 0;
  rxtc_regs i_rxtc_regs (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .factory_serial(factory_serial), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .trim(trim), .clock_divider(clock_divider), .clock_out(clock_out),
    .on_time_a(on_time_a), .on_time_b(on_time_b));
  // ============================================================
  // clock and hang guard
  // ============================================================
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  function automatic bit mapped(input int idx);
    return idx inside {['h0E:'h16], 'h1B, 'h1C, 'h1F, 'h20, 'h40, 'h41, 'h50};
  endfunction : mapped
  // trim, divider and on-time outputs against the model
  task automatic chk_outs;
    chk_word(32'(trim), 32'({m_radio[4:0], m_osc[0], m_gain[4:0], m_off[6:0]}));
    chk_word(32'(clock_divider), 32'(m_div));
    chk_word({18'h0, on_time_a.set_value}, 32'(ona));
    chk_word({17'h0, on_time_a.periods}, 32'(ona == 0 ? 16384 : ona));
    chk_word({18'h0, on_time_b.set_value}, 32'(onb));
    chk_word({17'h0, on_time_b.periods}, 32'(onb == 0 ? 16384 : onb));
  endtask : chk_outs
  // ============================================================
  // bus master: both write halves offered together, bready held
  // ============================================================
  task automatic axi_wr(input int idx, input logic [31:0] d, input logic [3:0] s = 4'hF);
    bit ad, dd;
    @(posedge aclk);
    awaddr <= 12'(idx * 4);
    awvalid <= 1;
    wdata <= d;
    wvalid <= 1;
    wstrb <= s;
    bready <= 1;
    ad = 0;
    dd = 0;
    forever begin
      @(posedge aclk);
      if (!ad && awready) begin ad = 1; awvalid <= 0; end
      if (!dd && wready) begin dd = 1; wvalid <= 0; end
      if (bvalid) break;
    end
    bready <= 0;
    chk_resp(bresp, mapped(idx) ? RESP_OKAY : RESP_SLVERR);
    if (s[0]) case (idx)
      'h12: m_radio = d[4:0];
      'h13: st_lo = d[7:0];
      'h14: st_mid = d[7:0];
      'h15: m_div = {d[3:0], st_mid[7:0], st_lo[7:0]};
      'h16: m_osc = d[4];
      'h1B: m_gain = d[4:0];
      'h1C: m_off = d[6:0];
      'h1F: sta = d[7:0];
      'h20: ona = {d[5:0], sta[7:0]};
      'h40: stb = d[7:0];
      'h41: onb = {d[5:0], stb[7:0]};
      default: ;
    endcase
    chk_outs;
  endtask : axi_wr
  task automatic axi_rd(input int idx, input logic [31:0] e = 32'h0);
    bit ad;
    @(posedge aclk);
    araddr <= 12'(idx * 4);
    arvalid <= 1;
    rready <= 1;
    ad = 0;
    forever begin
      @(posedge aclk);
      if (!ad && arready) begin ad = 1; arvalid <= 0; end
      if (rvalid) break;
    end
    rready <= 0;
    // serial bytes from 7..0 upward; write-only and unmapped read zero
    chk_word(rdata, (idx inside {['h0E:'h11]}) ? (factory_serial >> (8 * (idx - 14))) & 'hFF
      : e);
    chk_resp(rresp, mapped(idx) ? RESP_OKAY : RESP_SLVERR);
  endtask : axi_rd
  task automatic set_div(input logic [19:0] v);
    axi_wr('h13, 32'(v[7:0]));
    axi_wr('h14, 32'(v[15:8]));
    axi_wr('h15, 32'(v[19:16]));
  endtask : set_div
  // cycles between two rising edges of the divided clock
  task automatic period(input int div);
    int n, seen;
    logic p;
    n = 0;
    seen = 0;
    p = clock_out;
    repeat (8 * div + 8) begin
      @(posedge aclk);
      if (clock_out && !p) begin
        if (seen) break;
        seen = 1;
        n = 0;
      end
      n++;
      p = clock_out;
    end
    chk_word(32'(n), 32'(2 * div));
  endtask : period
  // ============================================================
  // main sequence
  // ============================================================
  initial begin
    void'($urandom(32'h428C1D60));
    @(posedge aclk);
    factory_serial <= $urandom;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk_outs;
    $display("test reset values done");
    for (i = 'h0E; i <= 'h11; i++) axi_rd(i);
    axi_wr('h0F, $urandom);
    axi_rd('h0F);
    $display("test serial done");
    for (i = 0; i < 16; i++) begin
      axi_wr('h12, 32'({1'($urandom), i[3:0]}));
      axi_wr('h16, 32'({i[0], 4'h0}));
      axi_wr('h1B, (i == 15) ? 32'h1F : 32'(5'($urandom)));
      axi_wr('h1C, 32'({i[1:0], 5'($urandom)}));
    end
    axi_rd('h1C);
    $display("test trims done");
    set_div(3);
    period(3);
    set_div(1);
    period(1);
    // clock enable low must freeze the divided clock and every setting
    ce <= 0;
    @(posedge aclk);
    held = clock_out;
    repeat (4) @(posedge aclk);
    chk_word(32'(clock_out), 32'(held));
    chk_outs;
    ce <= 1;
    set_div(20'($urandom));
    set_div(0);
    // divider zero toggles the output only every 2^20 cycles, so the status level is known
    axi_wr('h14, $urandom);
    axi_rd('h50, {30'h0, 1'b1, clock_out});
    $display("test divider done");
    on_vals = '{14'h1, 14'h3FFF, 14'h0, 14'($urandom)};
    foreach (on_vals[k]) begin
      axi_wr('h1F, 32'(on_vals[k][7:0]));
      axi_wr('h20, {26'($urandom), on_vals[k][13:8]});
      axi_wr('h40, 32'(on_vals[3 - k][7:0]));
      axi_wr('h41, {26'($urandom), on_vals[3 - k][13:8]});
    end
    $display("test on-time done");
    axi_wr('h30, $urandom);
    axi_rd('h30);
    axi_wr('h1B, 32'h1F, 4'h0);
    $display("test refusals done");
    final_report;
  end
endmodule : tb_receiver_trim_and_clock_regs
bind rxtc_regs rxtc_regs_asserts i_rxtc_regs_asserts (.aclk(aclk), .aresetn(aresetn),
  .ce(ce), .arvalid(arvalid), .arready(arready), .bvalid(bvalid), .bready(bready),
  .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .trim(trim),
  .clock_divider(clock_divider), .clock_out(clock_out), .on_time_a(on_time_a),
  .on_time_b(on_time_b));
`default_nettype wire
